// [hdl/clock_gate_pkg.sv]
// constants and types shared by the clock gate and its selectors
package clock_gate_pkg;

    // idle level of a selector output; the active phase is the opposite level
    localparam logic IDLE_RISE = 1'b0;
    localparam logic IDLE_FALL = 1'b1;

    // constant levels put on the unused leg of each gate
    localparam logic TIE_RISE = 1'b0;
    localparam logic TIE_FALL = 1'b1;

    // leg codes on a selector's select input
    localparam logic PICK_FIRST = 1'b0;
    localparam logic PICK_SECOND = 1'b1;

    // selector slots in the top level
    localparam int SLOT_GATE_RISE = 0;
    localparam int SLOT_GATE_FALL = 1;
    localparam int SLOT_CASCADE_LOW = 2;
    localparam int SLOT_CASCADE_HIGH = 3;
    localparam int SLOT_COUNT = 4;

    // reset values
    localparam logic RST_OUT_RISE = IDLE_RISE;
    localparam logic RST_OUT_FALL = IDLE_FALL;
    localparam logic RST_CUR = PICK_FIRST;

    typedef enum logic [1:0] {
        FOLLOW = 2'b01,
        HOLD = 2'b10
    } sel_state_t;

endpackage

// [hdl/clock_select_if.sv]
// two-leg clock selector connection between the top level and a selector
`timescale 1ns/100ps
`default_nettype none

interface clock_select_if;
    logic first_leg;
    logic second_leg;
    logic sel;
    logic out;
    logic holding;

    modport driver (
        output first_leg,
        output second_leg,
        output sel,
        input out,
        input holding
    );

    modport selector (
        input first_leg,
        input second_leg,
        input sel,
        output out,
        output holding
    );
endinterface

`default_nettype wire

// [hdl/glitchless_clock_selector.sv]
// glitch-free two-leg clock selector, sampled on the system clock
`timescale 1ns/100ps
`default_nettype none

module glitchless_clock_selector #(
    parameter logic IDLE_LEVEL = clock_gate_pkg::IDLE_RISE
) (
    input wire logic i_clk,
    input wire logic i_rst,
    clock_select_if.selector port_sel
);
    import clock_gate_pkg::*;

    localparam logic ACTIVE_LEVEL = ~IDLE_LEVEL;

    sel_state_t state;
    sel_state_t next_state;
    logic cur;
    logic next_cur;
    logic out_q;
    logic next_out;

    wire logic leg_cur;
    wire logic leg_tgt;
    wire logic change_req;
    wire logic cur_active;
    wire logic tgt_idle;

    // low select routes the first leg, high the second
    assign leg_cur = (cur == PICK_SECOND) ? port_sel.second_leg : port_sel.first_leg;
    assign leg_tgt = (port_sel.sel == PICK_SECOND) ? port_sel.second_leg : port_sel.first_leg;
    assign change_req = (port_sel.sel != cur);
    assign cur_active = (leg_cur == ACTIVE_LEVEL);
    // a target already at idle level is taken at once: the output is idle too,
    // so the hand-over point cannot show as an edge
    assign tgt_idle = (leg_tgt == IDLE_LEVEL);

    always_comb begin
        next_state = state;
        next_cur = cur;
        next_out = out_q;
        unique case (state)
            FOLLOW: begin
                if (!change_req || cur_active) begin
                    // an active phase in progress runs to its end
                    next_out = leg_cur;
                end else begin
                    next_state = HOLD;
                    next_out = IDLE_LEVEL;
                end
            end
            HOLD: begin
                // output parked idle until the requested leg reaches idle
                next_out = IDLE_LEVEL;
                if (tgt_idle) begin
                    next_cur = port_sel.sel;
                    next_state = FOLLOW;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            // start parked: a leg caught mid-phase at release must not leak a runt
            state <= HOLD;
            cur <= RST_CUR;
            out_q <= IDLE_LEVEL;
        end else begin
            state <= next_state;
            cur <= next_cur;
            out_q <= next_out;
        end
    end

    assign port_sel.out = out_q;
    assign port_sel.holding = (state == HOLD);

endmodule // glitchless_clock_selector

`default_nettype wire

// [hdl/glitch_free_clock_gate.sv]
// glitch-free clock gates of both polarities and a three-leg clock selector
//
// How it works
// - rise gate enabled before a rising edge passes that whole low-high-low pulse.
// - rise gate ignores enable changes while the input clock is high.
// - rise gate disabled before a rising edge blocks the pulse, output stays low.
// - disabling the rise gate finishes the high phase already on the output.
// - fall gate enabled before a falling edge passes that whole high-low-high pulse.
// - fall gate ignores enable changes while the input clock is low.
// - fall gate disabled before a falling edge blocks the pulse, output stays high.
// - disabling the fall gate finishes the low phase already on the output.
// - each gate is a selector: clock on first leg, idle constant second, inverted enable.
// - the selector swaps between clocks, even asynchronous ones, with no glitch or runt.
// - two selectors cascade into a three-leg glitch-free clock selector.
// - select low routes the first leg, select high routes the second leg.
// - after a select change the output idles until the new leg reaches idle level.
//
// all clock inputs are treated as levels sampled on i_clk; every selector output lags its
// source by one cycle per selector stage, so legs a and b of the three-leg path lag by two and leg c by one.
`timescale 1ns/100ps
`default_nettype none

module glitch_free_clock_gate (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_src_clk,
    input wire logic i_enable_rise,
    input wire logic i_enable_fall,
    input wire logic i_pick_clk_a,
    input wire logic i_pick_clk_b,
    input wire logic i_pick_clk_c,
    input wire logic [1:0] i_pick,
    output logic o_gated_rise,
    output logic o_gated_fall,
    output logic o_plain,
    output logic o_picked,
    output logic o_rise_parked,
    output logic o_fall_parked,
    output logic o_pick_switching
);
    import clock_gate_pkg::*;

    // per-slot idle level: the two gates differ, the cascade is rise-style
    localparam logic [SLOT_COUNT-1:0] SLOT_IDLE = {IDLE_RISE, IDLE_RISE, IDLE_FALL, IDLE_RISE};

    clock_select_if sel_bus [SLOT_COUNT] ();

    // enable high selects the clock leg; the select is the inverted enable
    wire logic rise_select;
    wire logic fall_select;
    assign rise_select = ~i_enable_rise;
    assign fall_select = ~i_enable_fall;

    // rising gate: clock on first leg, constant low on second
    assign sel_bus[SLOT_GATE_RISE].first_leg = i_src_clk;
    assign sel_bus[SLOT_GATE_RISE].second_leg = TIE_RISE;
    // enable is looked at only while the clock is low, so a change during the
    // high time waits for the next rising edge
    assign sel_bus[SLOT_GATE_RISE].sel = rise_select;

    // falling gate: clock on first leg, constant high on second
    assign sel_bus[SLOT_GATE_FALL].first_leg = i_src_clk;
    assign sel_bus[SLOT_GATE_FALL].second_leg = TIE_FALL;
    // mirrored: changes during the clock's low time are held off
    assign sel_bus[SLOT_GATE_FALL].sel = fall_select;

    // three-leg selector: first stage picks a or b, second picks that or c
    wire logic cascade_low_pick;
    wire logic cascade_high_pick;
    assign cascade_low_pick = i_pick[0];
    assign cascade_high_pick = i_pick[1];

    assign sel_bus[SLOT_CASCADE_LOW].first_leg = i_pick_clk_a;
    assign sel_bus[SLOT_CASCADE_LOW].second_leg = i_pick_clk_b;
    assign sel_bus[SLOT_CASCADE_LOW].sel = cascade_low_pick;

    assign sel_bus[SLOT_CASCADE_HIGH].first_leg = sel_bus[SLOT_CASCADE_LOW].out;
    assign sel_bus[SLOT_CASCADE_HIGH].second_leg = i_pick_clk_c;
    assign sel_bus[SLOT_CASCADE_HIGH].sel = cascade_high_pick;

    // every slot is the same selector, only its idle level differs
    genvar g;
    generate
        for (g = 0; g < SLOT_COUNT; g++) begin : g_slot
            glitchless_clock_selector #(
                .IDLE_LEVEL(SLOT_IDLE[g])
            ) u_selector (
                .i_clk(i_clk),
                .i_rst(i_rst),
                .port_sel(sel_bus[g])
            );
        end
    endgenerate

    // outputs of the selectors are already flip-flops; pass them straight out
    wire logic rise_out;
    wire logic fall_out;
    wire logic picked_out;
    assign rise_out = sel_bus[SLOT_GATE_RISE].out;
    assign fall_out = sel_bus[SLOT_GATE_FALL].out;
    assign picked_out = sel_bus[SLOT_CASCADE_HIGH].out;

    assign o_gated_rise = rise_out;
    assign o_gated_fall = fall_out;
    assign o_picked = picked_out;

    // ungated copy of the source clock with the same one-cycle lag as the gates,
    // so a feedback path tapped here lines up with the gated outputs
    logic plain_q;
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            plain_q <= RST_OUT_RISE;
        end else begin
            plain_q <= i_src_clk;
        end
    end
    assign o_plain = plain_q;

    // status: a gate is parked when it is holding idle with the clock cut off
    wire logic rise_hold;
    wire logic fall_hold;
    wire logic low_hold;
    wire logic high_hold;
    assign rise_hold = sel_bus[SLOT_GATE_RISE].holding;
    assign fall_hold = sel_bus[SLOT_GATE_FALL].holding;
    assign low_hold = sel_bus[SLOT_CASCADE_LOW].holding;
    assign high_hold = sel_bus[SLOT_CASCADE_HIGH].holding;

    logic rise_parked;
    logic fall_parked;
    logic pick_switching;
    wire logic next_rise_parked;
    wire logic next_fall_parked;
    wire logic next_pick_switching;

    // parked covers both the wait for idle and the disabled steady state;
    // a gate on its constant leg follows a level that never leaves idle
    assign next_rise_parked = rise_hold || (rise_select && (rise_out == IDLE_RISE));
    assign next_fall_parked = fall_hold || (fall_select && (fall_out == IDLE_FALL));
    assign next_pick_switching = low_hold || high_hold;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rise_parked <= 1'b0;
            fall_parked <= 1'b0;
            pick_switching <= 1'b0;
        end else begin
            rise_parked <= next_rise_parked;
            fall_parked <= next_fall_parked;
            pick_switching <= next_pick_switching;
        end
    end

    assign o_rise_parked = rise_parked;
    assign o_fall_parked = fall_parked;
    assign o_pick_switching = pick_switching;

endmodule // glitch_free_clock_gate

`default_nettype wire

// [bench/gate_props.sv]
// assertions on the two gated clock outputs
`timescale 1ns/100ps
`default_nettype none
module gate_props (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_src_clk,
    input wire logic i_enable_rise,
    input wire logic i_enable_fall,
    input wire logic o_gated_rise,
    input wire logic o_gated_fall
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    chk_rise_from_src: assert property (o_gated_rise |-> $past(i_src_clk))
        else $error("rise high without source");
    chk_rise_high_kept: assert property (o_gated_rise && i_src_clk |=> o_gated_rise)
        else $error("rise pulse cut short");
    chk_rise_blocked: assert property
        ((!i_enable_rise && !i_src_clk) ##1 !i_enable_rise |=> !o_gated_rise)
        else $error("rise pulse not blocked");
    chk_rise_passes: assert property
        ((i_enable_rise && !i_src_clk)[*2] ##1 i_enable_rise |=> o_gated_rise == $past(i_src_clk))
        else $error("rise not following source");
    chk_fall_from_src: assert property (!o_gated_fall |-> !$past(i_src_clk))
        else $error("fall low without source");
    chk_fall_low_kept: assert property (!o_gated_fall && !i_src_clk |=> !o_gated_fall)
        else $error("fall pulse cut short");
    chk_fall_blocked: assert property
        ((!i_enable_fall && i_src_clk) ##1 !i_enable_fall |=> o_gated_fall)
        else $error("fall pulse not blocked");
    chk_fall_passes: assert property
        ((i_enable_fall && i_src_clk)[*2] ##1 i_enable_fall |=> o_gated_fall == $past(i_src_clk))
        else $error("fall not following source");
    cover property ($fell(o_gated_rise) && !i_enable_rise);
    cover property ($rose(o_gated_fall) && !i_enable_fall);
    cover property (i_enable_rise && o_gated_rise);
endmodule // gate_props
`default_nettype wire

// [bench/clock_source_model.sv]
// clock sources feeding the gates and the clocked logic behind them
`timescale 1ns/100ps
`default_nettype none
module clock_source_model (
    input wire logic i_clk,
    input wire logic i_gated_rise,
    input wire logic i_gated_fall,
    output logic o_src_clk,
    output logic o_clk_a,
    output logic o_clk_b,
    output logic o_clk_c,
    output logic [7:0] o_rise_count,
    output logic [7:0] o_fall_count
);
    logic [7:0] phase = 8'h00;
    logic [7:0] rise_count = 8'h00;
    logic [7:0] fall_count = 8'h00;
    logic prev_rise = 1'b0;
    logic prev_fall = 1'b1;
    // edges move on the falling edge, clear of where the gates sample
    always_ff @(negedge i_clk) begin
        phase <= phase + 8'h01;
    end
    assign o_src_clk = phase[2];
    assign o_clk_a = phase[1];
    assign o_clk_b = phase[3];
    assign o_clk_c = phase[0];
    assign o_rise_count = rise_count;
    assign o_fall_count = fall_count;
    // downstream logic counts only the active edge of its gate
    always_ff @(posedge i_clk) begin
        prev_rise <= i_gated_rise;
        prev_fall <= i_gated_fall;
        if (i_gated_rise && !prev_rise) begin
            rise_count <= rise_count + 8'h01;
        end
        if (!i_gated_fall && prev_fall) begin
            fall_count <= fall_count + 8'h01;
        end
    end
endmodule // clock_source_model
`default_nettype wire

// [bench/glitch_free_clock_gate_tb.sv]
// bench for the glitch-free clock gates and the three-leg selector
`timescale 1ns/100ps
`default_nettype none
module glitch_free_clock_gate_tb;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic en_rise = 1'b0;
    logic en_fall = 1'b0;
    logic cut_fall = 1'b0;
    logic [1:0] pick = 2'b00;
    logic src, ca, cb, cc, g_rise, g_fall, plain, picked;
    logic park_r, park_f, switching;
    logic [7:0] n_rise, n_fall;
    int num_errors = 0;
    int checks_done = 0;
    wire logic act = cut_fall ? ~g_fall : g_rise;

    initial begin
        forever #12.5 i_clk = ~i_clk;
    end

    glitch_free_clock_gate i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_src_clk(src),
        .i_enable_rise(en_rise), .i_enable_fall(en_fall), .i_pick_clk_a(ca),
        .i_pick_clk_b(cb), .i_pick_clk_c(cc), .i_pick(pick), .o_gated_rise(g_rise),
        .o_gated_fall(g_fall), .o_plain(plain), .o_picked(picked), .o_rise_parked(park_r),
        .o_fall_parked(park_f), .o_pick_switching(switching));
    clock_source_model i_src (.i_clk(i_clk), .i_gated_rise(g_rise), .i_gated_fall(g_fall),
        .o_src_clk(src), .o_clk_a(ca), .o_clk_b(cb), .o_clk_c(cc),
        .o_rise_count(n_rise), .o_fall_count(n_fall));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // enables move one cycle after a source rise, far from either active edge
    task automatic align;
        @(posedge src);
        @(negedge i_clk);
    endtask

    task automatic count_pulses(input logic [7:0] exp_r, input logic [7:0] exp_f);
        logic [7:0] r0, f0;
        repeat (16) @(negedge i_clk);
        r0 = n_rise;
        f0 = n_fall;
        repeat (32) @(negedge i_clk);
        check(n_rise - r0, exp_r);
        check(n_fall - f0, exp_f);
    endtask

    // enables still low after reset: neither gate may let a pulse out
    task automatic t_reset_idle;
        logic leak;
        leak = 1'b0;
        repeat (12) begin
            @(negedge i_clk);
            leak = leak | g_rise | ~g_fall;
        end
        check(8'(leak), 8'h00);
        check(8'(park_r), 8'h01);
        check(8'(park_f), 8'h01);
    endtask

    task automatic t_pass;
        align;
        en_rise = 1'b1;
        en_fall = 1'b1;
        count_pulses(8'h04, 8'h04);
        check(8'(park_r), 8'h00);
        check(8'(park_f), 8'h00);
    endtask

    task automatic t_block;
        align;
        en_rise = 1'b0;
        en_fall = 1'b0;
        count_pulses(8'h00, 8'h00);
        check(8'(g_rise), 8'h00);
        check(8'(g_fall), 8'h01);
        check(8'(park_r), 8'h01);
        check(8'(park_f), 8'h01);
    endtask

    // drop the enable in the first cycle of an active phase: it must still run 4 cycles
    task automatic t_cut(input logic fall);
        int n;
        cut_fall = fall;
        en_rise = 1'b1;
        en_fall = 1'b1;
        repeat (16) @(negedge i_clk);
        repeat (8) if (act !== 1'b0) @(negedge i_clk);
        repeat (8) if (act !== 1'b1) @(negedge i_clk);
        if (fall)
            en_fall = 1'b0;
        else
            en_rise = 1'b0;
        n = 1;
        repeat (8) begin
            @(negedge i_clk);
            if (act === 1'b1) n++;
        end
        check(8'(n), 8'h04);
        check(8'(act), 8'h00);
    endtask

    // c feeds the second stage directly, so it lags one cycle less than a and b
    task automatic t_pick;
        logic h_clk;
        logic sw_seen;
        for (int p = 0; p < 4; p++) begin
            pick = 2'(p);
            sw_seen = 1'b0;
            repeat (24) begin
                @(negedge i_clk);
                sw_seen = sw_seen | switching;
            end
            check(8'(sw_seen), (p != 0) ? 8'h01 : 8'h00);
            check(8'(switching), 8'h00);
            repeat (8) begin
                h_clk = (p == 1) ? cb : ca;
                @(negedge i_clk);
                check(8'(picked), 8'((p >= 2) ? cc : h_clk));
                check(8'(plain), 8'(src));
            end
        end
    endtask

    initial begin
        repeat (20) @(negedge i_clk);
        check(8'(g_rise), 8'h00);
        check(8'(g_fall), 8'h01);
        i_rst = 1'b0;
        t_reset_idle;
        t_pass;
        t_cut(1'b0);
        t_cut(1'b1);
        t_block;
        t_pick;
        stop_test;
    end

    initial begin
        repeat (2000) @(posedge i_clk);
        num_errors++;
        stop_test;
    end
endmodule // glitch_free_clock_gate_tb

bind glitch_free_clock_gate gate_props i_props (.i_clk(i_clk), .i_rst(i_rst),
    .i_src_clk(i_src_clk), .i_enable_rise(i_enable_rise), .i_enable_fall(i_enable_fall),
    .o_gated_rise(o_gated_rise), .o_gated_fall(o_gated_fall));
`default_nettype wire
